//--- rtl/cps_defs.svh
// constants of the cell protection state machine
// assumes a 100 MHz system clock and an internal oscillator near 3.5 kHz
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH
`define CPS_CLK_HZ 100000000
`define CPS_OSC_HZ 3500
`define CPS_DIV_CYCLES (`CPS_CLK_HZ / `CPS_OSC_HZ)
`define CPS_OVERCHARGE_DELAY_US 100000
`define CPS_OVERDISCHARGE_DELAY_US 25000
`define CPS_OVERCURRENT_DELAY_US 10000
`define CPS_SHORT_CIRCUIT_DELAY_US 500
`define CPS_TICKS(us) (((us) * `CPS_OSC_HZ + 999999) / 1000000)
`define CPS_CNT_W 9
`endif

//--- rtl/cps_pkg.sv
// types of the cell protection state machine
// assumes cps_defs.svh supplies the numeric constants
package cps_pkg;
  // gray coded along normal -> overdischarge -> power-down
  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0,
    ST_OVERCHARGE = 3'h1,
    ST_OVERCURRENT = 3'h3,
    ST_OVERDISCHARGE = 3'h2,
    ST_POWERDOWN = 3'h6,
    ST_ABNORMAL_CHARGE = 3'h7,
    ST_SHORT_CIRCUIT = 3'h4
  } cps_state_t;

  // comparator results, 1 = condition true
  typedef struct packed {
    logic cellAboveOvercharge;
    logic cellAboveOverchargeRelease;
    logic cellBelowOverdischarge;
    logic cellAboveOverdischargeRelease;
    logic cellAboveZeroVoltInhibit;
    logic senseBelowChargerDetect;
    logic senseAboveOvercurrent;
    logic senseAboveShortCircuit;
    logic senseNearSupply;
  } cps_cmp_t;

  typedef struct packed {
    logic dischargeGateOut;
    logic chargeGateOut;
    logic chargeInhibit;
    logic powerDown;
    logic abnormalCharge;
  } cps_out_t;

  typedef struct packed {
    cps_cmp_t sync1;
    cps_cmp_t sync2;
    cps_state_t state;
    logic [14:0] divCnt;
    logic tick;
    logic [8:0] overchargeCnt;
    logic [8:0] overdischargeCnt;
    logic [8:0] overcurrentCnt;
    logic [8:0] shortCnt;
    logic [8:0] abnormalCnt;
    logic pdReleased;
    cps_out_t out;
  } cps_regs_t;
endpackage

//--- rtl/cps_fsm.sv
// cell protection state machine: comparators in, fet gate levels out
// assumes comparator inputs are asynchronous levels from the analog front
`timescale 1ns/1ns
`default_nettype none
`include "cps_defs.svh"
module cps_fsm #(
  parameter int DIV_CYCLES = `CPS_DIV_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire cps_pkg::cps_cmp_t cmpIn,
  output cps_pkg::cps_out_t gates
);
  localparam int CW = `CPS_CNT_W;
  localparam logic [CW-1:0] T_OVERCHARGE =
    CW'(`CPS_TICKS(`CPS_OVERCHARGE_DELAY_US));
  localparam logic [CW-1:0] T_OVERDISCHARGE =
    CW'(`CPS_TICKS(`CPS_OVERDISCHARGE_DELAY_US));
  localparam logic [CW-1:0] T_OVERCURRENT =
    CW'(`CPS_TICKS(`CPS_OVERCURRENT_DELAY_US));
  localparam logic [CW-1:0] T_SHORT =
    CW'(`CPS_TICKS(`CPS_SHORT_CIRCUIT_DELAY_US));
  localparam logic [14:0] DIV_LAST = 15'(DIV_CYCLES - 1);

  cps_pkg::cps_regs_t r_q;
  cps_pkg::cps_regs_t r_d;
  cps_pkg::cps_cmp_t c;

  // counts ticks while cond holds, restarts at zero when it drops
  function automatic logic [CW-1:0] delayCount(input logic cond,
      input logic tick, input logic [CW-1:0] cnt, input logic [CW-1:0] lim);
    logic [CW-1:0] n;
    n = '0;
    if (cond) begin
      n = cnt;
      if (tick && cnt < lim) begin
        n = cnt + 1'b1;
      end
    end
    return n;
  endfunction

  assign c = r_q.sync2;
  assign gates = r_q.out;

  always_comb begin
    r_d = r_q;
    r_d.sync1 = cmpIn;
    r_d.sync2 = r_q.sync1;
    // internal oscillator replaces an external timing capacitor
    r_d.tick = 1'b0;
    if (r_q.divCnt == DIV_LAST) begin
      r_d.divCnt = '0;
      r_d.tick = 1'b1;
    end else begin
      r_d.divCnt = r_q.divCnt + 15'h0001;
    end
    r_d.overchargeCnt = delayCount(r_q.state == cps_pkg::ST_NORMAL &&
      c.cellAboveOvercharge, r_q.tick, r_q.overchargeCnt, T_OVERCHARGE);
    r_d.overdischargeCnt = delayCount(c.cellBelowOverdischarge &&
      (r_q.state == cps_pkg::ST_NORMAL ||
       r_q.state == cps_pkg::ST_OVERCURRENT ||
       r_q.state == cps_pkg::ST_SHORT_CIRCUIT),
      r_q.tick, r_q.overdischargeCnt, T_OVERDISCHARGE);
    r_d.overcurrentCnt = delayCount(r_q.state == cps_pkg::ST_NORMAL &&
      c.senseAboveOvercurrent, r_q.tick, r_q.overcurrentCnt, T_OVERCURRENT);
    // timing runs only while both overcurrent and short levels are seen
    r_d.shortCnt = delayCount(r_q.state == cps_pkg::ST_NORMAL &&
      c.senseAboveOvercurrent && c.senseAboveShortCircuit,
      r_q.tick, r_q.shortCnt, T_SHORT);
    // armed only while the discharge gate is driven high
    r_d.abnormalCnt = delayCount(r_q.state == cps_pkg::ST_NORMAL &&
      r_q.out.dischargeGateOut && c.senseBelowChargerDetect,
      r_q.tick, r_q.abnormalCnt, T_OVERCHARGE);

    case (r_q.state)
      cps_pkg::ST_NORMAL: begin
        r_d.pdReleased = 1'b0;
        if (r_q.shortCnt == T_SHORT) begin
          r_d.state = cps_pkg::ST_SHORT_CIRCUIT;
        end else if (r_q.overcurrentCnt == T_OVERCURRENT) begin
          r_d.state = cps_pkg::ST_OVERCURRENT;
        end else if (r_q.overdischargeCnt == T_OVERDISCHARGE) begin
          r_d.state = cps_pkg::ST_OVERDISCHARGE;
        end else if (r_q.overchargeCnt == T_OVERCHARGE) begin
          r_d.state = cps_pkg::ST_OVERCHARGE;
        end else if (r_q.abnormalCnt == T_OVERCHARGE) begin
          r_d.state = cps_pkg::ST_ABNORMAL_CHARGE;
        end
      end
      cps_pkg::ST_OVERCHARGE: begin
        if (!c.cellAboveOverchargeRelease) begin
          r_d.state = cps_pkg::ST_NORMAL;
        end
      end
      cps_pkg::ST_OVERCURRENT, cps_pkg::ST_SHORT_CIRCUIT: begin
        if (r_q.overdischargeCnt == T_OVERDISCHARGE) begin
          r_d.state = cps_pkg::ST_POWERDOWN;
        end else if (!c.senseAboveOvercurrent) begin
          r_d.state = cps_pkg::ST_NORMAL;
        end
      end
      cps_pkg::ST_OVERDISCHARGE: begin
        if (r_q.pdReleased && !c.cellBelowOverdischarge) begin
          r_d.state = cps_pkg::ST_NORMAL;
        end else if (c.senseBelowChargerDetect &&
            !c.cellBelowOverdischarge) begin
          r_d.state = cps_pkg::ST_NORMAL;
        end else if (!c.senseBelowChargerDetect &&
            c.cellAboveOverdischargeRelease) begin
          r_d.state = cps_pkg::ST_NORMAL;
        end else if (!r_q.pdReleased && c.senseNearSupply) begin
          r_d.state = cps_pkg::ST_POWERDOWN;
        end
      end
      cps_pkg::ST_POWERDOWN: begin
        if (!c.senseNearSupply) begin
          r_d.state = cps_pkg::ST_OVERDISCHARGE;
          r_d.pdReleased = 1'b1;
        end
      end
      cps_pkg::ST_ABNORMAL_CHARGE: begin
        if (!c.senseBelowChargerDetect) begin
          r_d.state = cps_pkg::ST_NORMAL;
        end
      end
      default: begin
        r_d.state = cps_pkg::ST_NORMAL;
      end
    endcase

    // gate levels follow the next state so they change with it
    r_d.out.dischargeGateOut = (r_d.state == cps_pkg::ST_NORMAL ||
      r_d.state == cps_pkg::ST_OVERCHARGE ||
      r_d.state == cps_pkg::ST_ABNORMAL_CHARGE);
    r_d.out.chargeInhibit = !c.cellAboveZeroVoltInhibit;
    r_d.out.chargeGateOut = c.cellAboveZeroVoltInhibit &&
      r_d.state != cps_pkg::ST_OVERCHARGE &&
      r_d.state != cps_pkg::ST_ABNORMAL_CHARGE;
    r_d.out.powerDown = r_d.state == cps_pkg::ST_POWERDOWN;
    r_d.out.abnormalCharge = r_d.state == cps_pkg::ST_ABNORMAL_CHARGE;
  end

  // reset leaves the cell in normal with gates off until first update
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_normal_gates_on: assert property (
    r_q.state == cps_pkg::ST_NORMAL && $past(r_q.state) ==
      cps_pkg::ST_NORMAL && c.cellAboveZeroVoltInhibit &&
      $past(c.cellAboveZeroVoltInhibit) |->
      gates.dischargeGateOut && gates.chargeGateOut)
    else $error("normal state without both gates on");
  // gates are all zero out of reset, so skip the edge that leaves it
  a_zero_volt_clamp: assert property (
    $past(resetn) && !$past(c.cellAboveZeroVoltInhibit) |->
      !gates.chargeGateOut && gates.chargeInhibit)
    else $error("charge gate on for a zero volt cell");
  a_overdis_entry: assert property (
    r_q.state == cps_pkg::ST_NORMAL &&
      r_q.overdischargeCnt == T_OVERDISCHARGE &&
      r_q.shortCnt != T_SHORT && r_q.overcurrentCnt != T_OVERCURRENT |=>
      r_q.state == cps_pkg::ST_OVERDISCHARGE && !gates.dischargeGateOut)
    else $error("overdischarge delay expired without gate off");
  a_pd_entry: assert property (
    r_q.state == cps_pkg::ST_OVERDISCHARGE && !r_q.pdReleased &&
      c.senseNearSupply && c.cellBelowOverdischarge |=>
      r_q.state == cps_pkg::ST_POWERDOWN && gates.powerDown)
    else $error("power down not entered");
  a_pd_release: assert property (
    r_q.state == cps_pkg::ST_POWERDOWN && !c.senseNearSupply |=>
      r_q.state == cps_pkg::ST_OVERDISCHARGE && r_q.pdReleased)
    else $error("power down not released");
  a_abn_armed: assert property (
    !r_q.out.dischargeGateOut |=> r_q.abnormalCnt == '0)
    else $error("abnormal charge timed with discharge gate off");
  a_abn_clear: assert property (
    r_q.state == cps_pkg::ST_ABNORMAL_CHARGE &&
      !c.senseBelowChargerDetect |=> r_q.state == cps_pkg::ST_NORMAL)
    else $error("abnormal charge state not cleared");
  a_cnt_restart: assert property (
    !c.senseAboveOvercurrent |=> r_q.overcurrentCnt == '0)
    else $error("overcurrent counter kept its count");
  a_ovc_release: assert property (
    r_q.state == cps_pkg::ST_OVERCURRENT && !c.senseAboveOvercurrent &&
      r_q.overdischargeCnt != T_OVERDISCHARGE |=>
      r_q.state == cps_pkg::ST_NORMAL)
    else $error("overcurrent not released");
  a_tick_period: assert property (
    r_q.tick |=> !r_q.tick [*2])
    else $error("oscillator tick too frequent");

  c_short: cover property (r_q.state == cps_pkg::ST_SHORT_CIRCUIT);
  c_pd_cycle: cover property (r_q.state == cps_pkg::ST_POWERDOWN ##[1:50]
    r_q.state == cps_pkg::ST_OVERDISCHARGE);
  c_abnormal: cover property (r_q.state == cps_pkg::ST_ABNORMAL_CHARGE);
  c_overcharge: cover property (r_q.state == cps_pkg::ST_OVERCHARGE);
endmodule
`default_nettype wire

//--- dv/cps_cell_model.sv
// far-side model: cell, charger, load and fets seen as comparator levels
// assumes the bench sets cell and sense levels in millivolts
`timescale 1ns/1ns
`default_nettype none
module cps_cell_model #(
  parameter int OVERCHARGE_MV = 4200,
  parameter int OVERCHARGE_REL_MV = 4000,
  parameter int OVERDISCHARGE_MV = 2500,
  parameter int OVERDISCHARGE_REL_MV = 3000,
  parameter int ZERO_VOLT_MV = 1000,
  parameter int CHARGER_DETECT_MV = -100,
  parameter int OVERCURRENT_MV = 100,
  parameter int SHORT_MV = 800,
  parameter int NEAR_SUPPLY_MV = 1200
) (
  input var int cellMv,
  input var int senseMv,
  input wire logic senseFloat,
  input wire cps_pkg::cps_out_t gates,
  output wire cps_pkg::cps_cmp_t cmpIn
);
  int senseEff;
  // senseFloat: no low path on sense (open or load), so it sits at supply
  // as soon as the discharge gate is off
  assign senseEff = (senseFloat && !gates.dischargeGateOut) ? cellMv : senseMv;
  assign cmpIn.cellAboveOvercharge = cellMv > OVERCHARGE_MV;
  assign cmpIn.cellAboveOverchargeRelease = cellMv > OVERCHARGE_REL_MV;
  assign cmpIn.cellBelowOverdischarge = cellMv < OVERDISCHARGE_MV;
  assign cmpIn.cellAboveOverdischargeRelease = cellMv >= OVERDISCHARGE_REL_MV;
  assign cmpIn.cellAboveZeroVoltInhibit = cellMv > ZERO_VOLT_MV;
  assign cmpIn.senseBelowChargerDetect = senseEff < CHARGER_DETECT_MV;
  assign cmpIn.senseAboveOvercurrent = senseEff >= OVERCURRENT_MV;
  assign cmpIn.senseAboveShortCircuit = senseEff >= SHORT_MV;
  assign cmpIn.senseNearSupply = (cellMv - senseEff) <= NEAR_SUPPLY_MV;
endmodule
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the cell protection state machine
// assumes a shortened oscillator divider; delay counts in ticks are fixed
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int DIV = 4;
  localparam int OCH = 350 * DIV;
  // 25 ms at 3.5 kHz is 87.5 ticks, rounded up
  localparam int ODD = 88 * DIV;
  localparam int OCU = 35 * DIV;
  localparam int SHT = 2 * DIV;
  typedef struct {int c; int s; bit f; int n; logic [4:0] e;} cps_row_t;
  // before/after pairs bracket one tick of phase uncertainty
  // abnormal timing starts about 4 cycles into the row that re-enters
  // normal, hence the shorter wait before its trip
  cps_row_t rows[27] = '{
    '{3600, 0, 0, 10, 5'h18},
    '{4400, 0, 0, OCH - 5, 5'h18},
    '{4400, 0, 0, 14, 5'h10},
    '{4100, 0, 0, 10, 5'h10},
    '{3900, 0, 0, 10, 5'h18},
    '{3600, 300, 0, OCU - 5, 5'h18},
    '{3600, 300, 0, 14, 5'h08},
    '{3600, 0, 0, 10, 5'h18},
    '{2000, 0, 0, ODD - 5, 5'h18},
    '{2000, 0, 0, 14, 5'h08},
    '{2000, 0, 1, 10, 5'h0a},
    '{2000, -300, 0, 10, 5'h08},
    '{2700, -300, 0, 10, 5'h18},
    '{2700, -300, 0, OCH - 15, 5'h18},
    '{2700, -300, 0, 14, 5'h11},
    '{2700, 0, 0, 10, 5'h18},
    '{2000, 0, 0, ODD + 9, 5'h08},
    '{2700, 0, 0, 10, 5'h08},
    '{3100, 0, 0, 10, 5'h18},
    '{2000, 0, 0, ODD + 9, 5'h08},
    '{2700, -300, 0, 10, 5'h18},
    '{500, 0, 0, 10, 5'h14},
    '{3600, 0, 0, 10, 5'h18},
    '{2000, 300, 1, OCU + 9, 5'h08},
    '{2000, 300, 1, ODD - OCU, 5'h0a},
    '{3600, -300, 0, 10, 5'h18},
    '{3600, 0, 0, 10, 5'h18}};
  logic clock;
  logic resetn;
  int cellMv;
  int senseMv;
  logic senseFloat;
  cps_pkg::cps_cmp_t cmpIn;
  cps_pkg::cps_out_t gates;
  int nErrors;
  int checks;
  int cycles = 0;

  cps_fsm #(.DIV_CYCLES(DIV)) i_dut (
    .clock(clock),
    .resetn(resetn),
    .cmpIn(cmpIn),
    .gates(gates)
  );

  cps_cell_model i_cell (
    .cellMv(cellMv),
    .senseMv(senseMv),
    .senseFloat(senseFloat),
    .gates(gates),
    .cmpIn(cmpIn)
  );

  task automatic final_report();
    if (nErrors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    checks++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: gates %h, expected %h", $time, seen, exp);
    end
  endtask

  // called at a falling edge; levels change there, then n cycles pass
  task automatic step(input int c, input int s, input bit f, input int n,
                      input logic [4:0] e);
    cellMv = c;
    senseMv = s;
    senseFloat = f;
    repeat (n) @(negedge clock);
    check(gates, e);
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // whole run needs about 4900 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      final_report();
    end
  end

  initial begin
    resetn = 1'b0;
    cellMv = 3600;
    senseMv = 0;
    senseFloat = 1'b0;
    nErrors = 0;
    checks = 0;
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    foreach (rows[i]) begin
      step(rows[i].c, rows[i].s, rows[i].f, rows[i].n, rows[i].e);
    end
    step(3600, 1000, 0, SHT + 6, 5'h08);
    step(3600, 0, 0, 10, 5'h18);
    step(3600, 300, 0, OCU - 20, 5'h18);
    step(3600, 0, 0, 2, 5'h18);
    step(3600, 300, 0, OCU - 20, 5'h18);
    step(3600, 0, 0, 10, 5'h18);
    step(500, 0, 0, 2, 5'h18);
    step(500, 0, 0, 2, 5'h14);
    step(3600, 0, 0, 10, 5'h18);
    // reset in mid-run: gates drop, then restart from zeroed synchronisers
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    check(gates, 5'h00);
    resetn = 1'b1;
    @(negedge clock);
    check(gates, 5'h14);
    step(3600, 0, 0, 10, 5'h18);
    final_report();
  end
endmodule
`default_nettype wire
